// ---- hdl/spxia_expander.sv ----
// two-port 8-bit expander: change capture, open-drain interrupt, pair access over two wires
// assumes scl/sda/int resolved outside from the enables; link_clk_i free running and fast
//
// Contract
// - writes to both capture registers are discarded, contents unchanged
// - capture register holds its port pin levels at the change event
// - rate bit 0 detects within 32 ms, bit 1 within 200 us
// - control bit 0 is rate select, reset zero; bits 7..1 read zero
// - second control address accesses the same control register
// - interrupt pulled low on a port change, otherwise released
// - only input-configured pins can raise the interrupt
// - interrupt holds until its port data or capture register is read
// - change reverting before a read drops the interrupt, capture kept
// - clearing is per port; one port's read never clears the other
// - only the first change after interrupt reset loads the capture
// - after self-reset a new change reasserts and captures again
// - first byte to commanded register, second to its pair partner
// - twelve command values form six pairs, two commands per pair
// - a write accepts any number of bytes, all within one pair
// - read returns commanded register then partner, any byte count
// - from ninth clock falling edge scl held low until access done
// - port read gives pin levels xor polarity register; port write updates the output latch
// - direction bit set means input; all inputs after reset
`default_nettype none

module spxia_expander #(
    parameter int SLOW_SAMPLE_CYCLES = spxia_pkg::SLOW_SAMPLE_CYCLES,
    parameter logic [3:0] ADDR_FIXED = spxia_pkg::ADDR_FIXED
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [2:0] addr_pins_i,
    input wire logic [7:0] port0_pins_i,
    output logic [7:0] port0_pins_o,
    output logic [7:0] port0_pins_oe_o,
    input wire logic [7:0] port1_pins_i,
    output logic [7:0] port1_pins_o,
    output logic [7:0] port1_pins_oe_o,
    output logic int_o,
    output logic int_oe_o
);
    localparam int CW = spxia_pkg::SAMPLE_CNT_W;

    // ===========================================
    // core domain: registers, sampling, change capture
    logic [7:0] pin_s1 [2];
    logic [7:0] pin_s2 [2];
    logic [7:0] samp [2];
    logic [7:0] ref_v [2];
    logic [7:0] cap [2];
    logic [7:0] latch [2];
    logic [7:0] pol [2];
    logic [7:0] dir [2];
    logic [1:0] act;
    logic rate_sel;
    logic [CW-1:0] smp_cnt;
    logic rq_s1, rq_s2, rq_d, ack_tgl;
    logic [7:0] rdata;
    logic [7:0] next_pin_s1 [2];
    logic [7:0] next_pin_s2 [2];
    logic [7:0] next_samp [2];
    logic [7:0] next_ref_v [2];
    logic [7:0] next_cap [2];
    logic [7:0] next_latch [2];
    logic [7:0] next_pol [2];
    logic [7:0] next_dir [2];
    logic [1:0] next_act;
    logic next_rate_sel;
    logic [CW-1:0] next_smp_cnt;
    logic next_rq_s1, next_rq_s2, next_rq_d, next_ack_tgl;
    logic [7:0] next_rdata;
    logic [7:0] diff [2];
    logic [CW-1:0] smp_limit;
    logic tick, acc;
    // link-side request bundle, held stable while a request is open
    logic req_tgl, req_wr;
    logic [7:0] req_wdata;
    logic [3:0] ptr;

    // port data or capture read of port p clears its change
    function automatic logic clears_port(input logic [3:0] idx, input int p);
        clears_port = (idx == spxia_pkg::REG_PORT0 + 4'(p))
            || (idx == spxia_pkg::REG_CAPTURE0 + 4'(p));
    endfunction

    assign acc = rq_s2 ^ rq_d;
    assign smp_limit = rate_sel ? CW'(spxia_pkg::FAST_SAMPLE_CYCLES - 1)
                                : CW'(SLOW_SAMPLE_CYCLES - 1);
    assign tick = (smp_cnt >= smp_limit);

    always_comb begin
        next_pin_s1 = '{port0_pins_i, port1_pins_i};
        next_pin_s2 = pin_s1;
        next_samp = samp;
        next_ref_v = ref_v;
        next_cap = cap;
        next_latch = latch;
        next_pol = pol;
        next_dir = dir;
        next_rate_sel = rate_sel;
        next_rq_s1 = req_tgl;
        next_rq_s2 = rq_s1;
        next_rq_d = rq_s2;
        next_ack_tgl = ack_tgl;
        next_rdata = rdata;
        // slow scan saves power, the fast one costs current
        next_smp_cnt = tick ? '0 : smp_cnt + CW'(1);
        for (int p = 0; p < 2; p++) begin
            if (tick) begin
                next_samp[p] = pin_s2[p];
            end
            diff[p] = (samp[p] ^ ref_v[p]) & dir[p];
            next_act[p] = |diff[p];
            if (next_act[p] && !act[p]) begin
                next_cap[p] = samp[p];
            end
        end
        if (acc) begin
            next_ack_tgl = ~ack_tgl;
            if (req_wr) begin
                case (ptr)
                    spxia_pkg::REG_PORT0, spxia_pkg::REG_LATCH0: next_latch[0] = req_wdata;
                    spxia_pkg::REG_PORT1, spxia_pkg::REG_LATCH1: next_latch[1] = req_wdata;
                    spxia_pkg::REG_POL0: next_pol[0] = req_wdata;
                    spxia_pkg::REG_POL1: next_pol[1] = req_wdata;
                    spxia_pkg::REG_DIR0: next_dir[0] = req_wdata;
                    spxia_pkg::REG_DIR1: next_dir[1] = req_wdata;
                    spxia_pkg::REG_CONTROL, spxia_pkg::REG_CONTROL_ALIAS: begin
                        next_rate_sel = req_wdata[spxia_pkg::CTL_RATE_BIT];
                    end
                    default: begin
                        // capture registers and unused commands drop the byte
                        next_rdata = rdata;
                    end
                endcase
            end else begin
                case (ptr)
                    spxia_pkg::REG_PORT0: next_rdata = pin_s2[0] ^ pol[0];
                    spxia_pkg::REG_PORT1: next_rdata = pin_s2[1] ^ pol[1];
                    spxia_pkg::REG_LATCH0: next_rdata = latch[0];
                    spxia_pkg::REG_LATCH1: next_rdata = latch[1];
                    spxia_pkg::REG_POL0: next_rdata = pol[0];
                    spxia_pkg::REG_POL1: next_rdata = pol[1];
                    spxia_pkg::REG_DIR0: next_rdata = dir[0];
                    spxia_pkg::REG_DIR1: next_rdata = dir[1];
                    spxia_pkg::REG_CAPTURE0: next_rdata = cap[0];
                    spxia_pkg::REG_CAPTURE1: next_rdata = cap[1];
                    spxia_pkg::REG_CONTROL, spxia_pkg::REG_CONTROL_ALIAS: begin
                        next_rdata = {7'h00, rate_sel};
                    end
                    default: next_rdata = spxia_pkg::UNMAPPED_READ;
                endcase
                for (int p = 0; p < 2; p++) begin
                    // a change landing this cycle still shows next cycle
                    if (clears_port(ptr, p)) begin
                        next_ref_v[p] = samp[p];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_s1 <= '{8'h00, 8'h00};
            pin_s2 <= '{8'h00, 8'h00};
            samp <= '{8'h00, 8'h00};
            ref_v <= '{8'h00, 8'h00};
            cap <= '{spxia_pkg::CAPTURE_RESET, spxia_pkg::CAPTURE_RESET};
            latch <= '{spxia_pkg::LATCH_RESET, spxia_pkg::LATCH_RESET};
            pol <= '{spxia_pkg::POL_RESET, spxia_pkg::POL_RESET};
            dir <= '{spxia_pkg::DIR_RESET, spxia_pkg::DIR_RESET};
            act <= 2'h0;
            rate_sel <= 1'b0;
            smp_cnt <= '0;
            rq_s1 <= 1'b0;
            rq_s2 <= 1'b0;
            rq_d <= 1'b0;
            ack_tgl <= 1'b0;
            rdata <= 8'h00;
        end else begin
            pin_s1 <= next_pin_s1;
            pin_s2 <= next_pin_s2;
            samp <= next_samp;
            ref_v <= next_ref_v;
            cap <= next_cap;
            latch <= next_latch;
            pol <= next_pol;
            dir <= next_dir;
            act <= next_act;
            rate_sel <= next_rate_sel;
            smp_cnt <= next_smp_cnt;
            rq_s1 <= next_rq_s1;
            rq_s2 <= next_rq_s2;
            rq_d <= next_rq_d;
            ack_tgl <= next_ack_tgl;
            rdata <= next_rdata;
        end
    end

    assign port0_pins_o = latch[0];
    assign port1_pins_o = latch[1];
    assign port0_pins_oe_o = ~dir[0];
    assign port1_pins_oe_o = ~dir[1];
    assign int_o = 1'b0;
    assign int_oe_o = |act;

    // ===========================================
    // link domain: two-wire slave engine
    spxia_pkg::spxia_link_state_t st, next_st;
    logic scl1, scl2, scl_d, sda1, sda2, sda_d, ak1, ak2, ak_d;
    logic [2:0] ad1, ad2;
    logic [3:0] bitcnt, next_bitcnt, next_ptr;
    logic [7:0] shreg, next_shreg, next_req_wdata;
    logic rw, next_rw, mack, next_mack, sda_drv, next_sda_drv, scl_hold, next_scl_hold;
    logic next_req_tgl, next_req_wr;
    logic scl_rise, scl_fall, bus_start, bus_stop, ack_edge;

    assign scl_rise = scl2 && !scl_d;
    assign scl_fall = !scl2 && scl_d;
    assign bus_start = scl2 && scl_d && sda_d && !sda2;
    assign bus_stop = scl2 && scl_d && !sda_d && sda2;
    assign ack_edge = ak2 ^ ak_d;

    always_comb begin
        next_st = st;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_rw = rw;
        next_mack = mack;
        next_ptr = ptr;
        next_sda_drv = sda_drv;
        next_scl_hold = scl_hold;
        next_req_tgl = req_tgl;
        next_req_wr = req_wr;
        next_req_wdata = req_wdata;
        if (bus_start && st != spxia_pkg::L_ACCESS) begin
            next_st = spxia_pkg::L_ADDR;
            next_bitcnt = 4'h0;
            next_sda_drv = 1'b0;
        end else if (bus_stop && st != spxia_pkg::L_ACCESS) begin
            next_st = spxia_pkg::L_IDLE;
            next_sda_drv = 1'b0;
        end else begin
            case (st)
                spxia_pkg::L_ADDR, spxia_pkg::L_CMD, spxia_pkg::L_WDATA: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda2};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        next_sda_drv = 1'b1;
                        if (st == spxia_pkg::L_ADDR) begin
                            next_rw = shreg[0];
                            next_st = spxia_pkg::L_ADDR_ACK;
                            if (shreg[7:1] != {ADDR_FIXED[3:0], ad2}) begin
                                next_sda_drv = 1'b0;
                                next_st = spxia_pkg::L_IDLE;
                            end
                        end else if (st == spxia_pkg::L_CMD) begin
                            next_ptr = shreg[3:0];
                            next_st = spxia_pkg::L_CMD_ACK;
                        end else begin
                            next_st = spxia_pkg::L_WDATA_ACK;
                        end
                    end
                end
                spxia_pkg::L_ADDR_ACK, spxia_pkg::L_CMD_ACK, spxia_pkg::L_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_sda_drv = 1'b0;
                        next_bitcnt = 4'h0;
                        if (st == spxia_pkg::L_CMD_ACK
                            || (st == spxia_pkg::L_ADDR_ACK && !rw)) begin
                            next_st = (st == spxia_pkg::L_ADDR_ACK) ? spxia_pkg::L_CMD
                                                                     : spxia_pkg::L_WDATA;
                        end else begin
                            // stretch here until the core domain answers
                            next_scl_hold = 1'b1;
                            next_req_wr = !rw;
                            next_req_wdata = shreg;
                            next_req_tgl = ~req_tgl;
                            next_st = spxia_pkg::L_ACCESS;
                        end
                    end
                end
                spxia_pkg::L_ACCESS: begin
                    if (ack_edge) begin
                        next_scl_hold = 1'b0;
                        next_ptr = ptr ^ 4'h1;
                        next_bitcnt = 4'h0;
                        if (rw) begin
                            next_shreg = rdata;
                            next_sda_drv = ~rdata[7];
                            next_st = spxia_pkg::L_RDATA;
                        end else begin
                            next_st = spxia_pkg::L_WDATA;
                        end
                    end
                end
                spxia_pkg::L_RDATA: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h7) begin
                            next_sda_drv = 1'b0;
                            next_st = spxia_pkg::L_RACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_sda_drv = ~shreg[6];
                            next_bitcnt = bitcnt + 4'h1;
                        end
                    end
                end
                spxia_pkg::L_RACK: begin
                    if (scl_rise) begin
                        next_mack = !sda2;
                    end else if (scl_fall) begin
                        next_st = spxia_pkg::L_IDLE;
                        if (mack) begin
                            next_scl_hold = 1'b1;
                            next_req_wr = 1'b0;
                            next_req_tgl = ~req_tgl;
                            next_st = spxia_pkg::L_ACCESS;
                        end
                    end
                end
                default: next_st = spxia_pkg::L_IDLE;
            endcase
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {scl1, scl2, scl_d, sda1, sda2, sda_d} <= 6'h3f;
            {ak1, ak2, ak_d} <= 3'h0;
            ad1 <= 3'h0;
            ad2 <= 3'h0;
            st <= spxia_pkg::L_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            rw <= 1'b0;
            mack <= 1'b0;
            ptr <= spxia_pkg::REG_PORT0;
            sda_drv <= 1'b0;
            scl_hold <= 1'b0;
            req_tgl <= 1'b0;
            req_wr <= 1'b0;
            req_wdata <= 8'h00;
        end else begin
            {scl1, scl2, scl_d} <= {scl_i, scl1, scl2};
            {sda1, sda2, sda_d} <= {sda_i, sda1, sda2};
            {ak1, ak2, ak_d} <= {ack_tgl, ak1, ak2};
            ad1 <= addr_pins_i;
            ad2 <= ad1;
            st <= next_st;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            rw <= next_rw;
            mack <= next_mack;
            ptr <= next_ptr;
            sda_drv <= next_sda_drv;
            scl_hold <= next_scl_hold;
            req_tgl <= next_req_tgl;
            req_wr <= next_req_wr;
            req_wdata <= next_req_wdata;
        end
    end

    assign scl_o = 1'b0;
    assign scl_oe_o = scl_hold;
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_drv;

    // ===========================================
    // checks
    sequence cap_write_s;
        acc && req_wr && ptr == spxia_pkg::REG_CAPTURE0;
    endsequence
    sequence ctl_read_s;
        acc && !req_wr && (ptr == spxia_pkg::REG_CONTROL || ptr == spxia_pkg::REG_CONTROL_ALIAS);
    endsequence

    cap_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        act[0] && $past(act[0]) |-> cap[0] == $past(cap[0]))
        else $error("capture changed while change pending");
    cap_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(act[0]) |-> cap[0] == $past(samp[0]))
        else $error("capture not loaded with sampled pins");
    ro_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cap_write_s ##1 !$rose(act[0]) |-> cap[0] == $past(cap[0]))
        else $error("capture register took a written byte");
    ctl_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ctl_read_s |=> rdata == {7'h00, $past(rate_sel)})
        else $error("control read value wrong");
    alias_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        acc && req_wr && ptr == spxia_pkg::REG_CONTROL_ALIAS |=> rate_sel == $past(req_wdata[0]))
        else $error("alias write missed control register");
    int_pin_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (|((samp[1] ^ ref_v[1]) & dir[1])) |=> int_oe_o)
        else $error("interrupt not raised on change");
    out_mask_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ((samp[0] ^ ref_v[0]) & dir[0]) == 8'h00 && ((samp[1] ^ ref_v[1]) & dir[1]) == 8'h00
        |=> !int_oe_o)
        else $error("interrupt raised without input change");
    per_port_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        acc && !req_wr && ptr == spxia_pkg::REG_PORT0 |=> ref_v[1] == $past(ref_v[1])
        && ref_v[0] == $past(samp[0]))
        else $error("port read cleared wrong port");
    scan_rate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rate_sel && $past(rate_sel) |-> smp_cnt < CW'(spxia_pkg::FAST_SAMPLE_CYCLES))
        else $error("fast scan period exceeded");
    stretch_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        st == spxia_pkg::L_ACCESS |-> scl_oe_o)
        else $error("clock not held during access");
    // core answers within a few cycles of each clock; 40 link cycles leaves margin
    stretch_end_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        $rose(scl_oe_o) |-> st == spxia_pkg::L_ACCESS ##[1:40] !scl_oe_o)
        else $error("clock stretch never released");
    pair_step_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        st == spxia_pkg::L_ACCESS && ack_edge |=> ptr == ($past(ptr) ^ 4'h1))
        else $error("pair pointer did not alternate");
endmodule

`default_nettype wire

// ---- hdl/spxia_pkg.sv ----
// constants and types for the port expander change-capture and pair-access block
// assumes a 10 MHz core clock; the two-wire link runs on its own clock
`default_nettype none

package spxia_pkg;
    // ===========================================
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int SLOW_DETECT_US = 32000;
    localparam int FAST_DETECT_US = 200;
    localparam int SLOW_SAMPLE_CYCLES = SLOW_DETECT_US * CLK_PER_US;
    localparam int FAST_SAMPLE_CYCLES = FAST_DETECT_US * CLK_PER_US;
    localparam int SAMPLE_CNT_W = 19;

    // ===========================================
    // register indices (command byte values)
    localparam logic [3:0] REG_PORT0 = 4'h0;
    localparam logic [3:0] REG_PORT1 = 4'h1;
    localparam logic [3:0] REG_LATCH0 = 4'h2;
    localparam logic [3:0] REG_LATCH1 = 4'h3;
    localparam logic [3:0] REG_POL0 = 4'h4;
    localparam logic [3:0] REG_POL1 = 4'h5;
    localparam logic [3:0] REG_DIR0 = 4'h6;
    localparam logic [3:0] REG_DIR1 = 4'h7;
    localparam logic [3:0] REG_CAPTURE0 = 4'h8;
    localparam logic [3:0] REG_CAPTURE1 = 4'h9;
    localparam logic [3:0] REG_CONTROL = 4'ha;
    localparam logic [3:0] REG_CONTROL_ALIAS = 4'hb;

    // ===========================================
    // fields and reset values
    localparam int CTL_RATE_BIT = 0;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] POL_RESET = 8'h00;
    localparam logic [7:0] CAPTURE_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [3:0] ADDR_FIXED = 4'h4;

    // ===========================================
    // link engine states
    typedef enum logic [3:0] {
        L_IDLE = 4'b0000,
        L_ADDR = 4'b0001,
        L_ADDR_ACK = 4'b0010,
        L_CMD = 4'b0011,
        L_CMD_ACK = 4'b0100,
        L_WDATA = 4'b0101,
        L_WDATA_ACK = 4'b0110,
        L_ACCESS = 4'b0111,
        L_RDATA = 4'b1000,
        L_RACK = 4'b1001
    } spxia_link_state_t;
endpackage

`default_nettype wire

// ---- hdl/spxia_unused_none.sv ----
// holds no logic; every design module sits in the expander file
`default_nettype none
`default_nettype wire

// ---- test/serial_port_expander_irq_access_bench.sv ----
// self-checking bench: pair access, control alias, change capture
// assumes pads resolve from latch, enable and external drive
`default_nettype none
module serial_port_expander_irq_access_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] ADR = {spxia_pkg::ADDR_FIXED, 3'h5};
    logic clk_i, link_clk, rst_b, m_scl, m_sda, scl_oe, sda_oe, int_oe, scl, sda;
    logic [7:0] ext0, ext1, p0_o, p0_oe, p1_o, p1_oe, pad0, pad1;
    logic scl_v, sda_v, int_v;
    int n_errors, num_checks, cycles;
    assign scl = ~(m_scl | scl_oe);
    assign sda = ~(m_sda | sda_oe);
    assign pad0 = (p0_o & p0_oe) | (ext0 & ~p0_oe);
    assign pad1 = (p1_o & p1_oe) | (ext1 & ~p1_oe);
    // small sample count keeps the slow rate short
    spxia_expander #(.SLOW_SAMPLE_CYCLES(200)) DUT (.clk_i(clk_i), .rst_b_i(rst_b),
        .link_clk_i(link_clk), .scl_i(scl), .scl_o(scl_v), .scl_oe_o(scl_oe), .sda_i(sda),
        .sda_o(sda_v), .sda_oe_o(sda_oe), .addr_pins_i(3'h5), .port0_pins_i(pad0),
        .port0_pins_o(p0_o), .port0_pins_oe_o(p0_oe), .port1_pins_i(pad1),
        .port1_pins_o(p1_o), .port1_pins_oe_o(p1_oe), .int_o(int_v), .int_oe_o(int_oe));
    spxia_master M (.clk_i(clk_i), .scl_i(scl), .sda_i(sda), .scl_low_o(m_scl),
        .sda_low_o(m_sda));
    // ======================================
    // clocks and timeout
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            stop_test();
        end
    end
    // ======================================
    // tasks
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d[$]);
        logic [8:0] r;
        M.start();
        M.xfer({ADR, 2'b01}, r);
        chk({7'h00, r[0]}, 8'h00);
        M.xfer({c, 1'b1}, r);
        foreach (d[i]) M.xfer({d[i], 1'b1}, r);
        M.stop();
    endtask
    // last byte gets a nack, which ends the read
    task automatic rd(input logic [7:0] c, input logic [7:0] e[$]);
        logic [8:0] r;
        M.start();
        M.xfer({ADR, 2'b01}, r);
        M.xfer({c, 1'b1}, r);
        M.start();
        M.xfer({ADR, 2'b11}, r);
        foreach (e[i]) begin
            M.xfer({8'hff, i == e.size() - 1}, r);
            chk(r[8:1], e[i]);
        end
        M.stop();
    endtask
    task automatic wint(input int n, input logic e);
        repeat (n) @(posedge clk_i);
        #1;
        chk({7'h00, int_oe}, {7'h00, e});
    endtask
    // ======================================
    // scenarios
    initial begin
        {ext0, ext1, rst_b} = '0;
        repeat (5) @(posedge clk_i);
        #1;
        rst_b = 1'b1;
        chk(p0_oe, 8'h00);
        chk({5'h00, int_v, scl_v, sda_v}, 8'h00);
        wint(20, 1'b0);
        rd(8'h06, '{8'hff, 8'hff});
        rd(8'h0b, '{8'h00});
        wr(8'h03, '{8'ha5, 8'h5a, 8'hc3});
        chk(p1_o, 8'hc3);
        chk(p0_o, 8'h5a);
        rd(8'h02, '{8'h5a, 8'hc3, 8'h5a});
        wr(8'h0b, '{8'hff});
        rd(8'h0a, '{8'h01, 8'h01});
        wr(8'h0a, '{8'h00});
        wr(8'h06, '{8'h0f});
        chk(p0_oe, 8'hf0);
        rd(8'h00, '{8'h50});
        wr(8'h02, '{8'ha5});
        wint(500, 1'b0);
        ext0 = 8'h01;
        wint(300, 1'b1);
        ext0 = 8'h03;
        ext1 = 8'h01;
        wint(300, 1'b1);
        rd(8'h08, '{8'ha1});
        wint(300, 1'b1);
        // both capture registers take a byte that must be dropped
        wr(8'h08, '{8'h00, 8'h00});
        rd(8'h09, '{8'h01});
        wint(300, 1'b0);
        ext1 = 8'h03;
        wint(300, 1'b1);
        ext1 = 8'h01;
        wint(300, 1'b0);
        rd(8'h09, '{8'h03});
        ext1 = 8'h07;
        wint(300, 1'b1);
        rd(8'h09, '{8'h07, 8'ha1});
        wr(8'h0a, '{8'h01});
        ext0 = 8'h07;
        for (int i = 0; i < 2010 && int_oe !== 1'b1; i++) @(posedge clk_i);
        chk({7'h00, int_oe}, 8'h01);
        // a data port read clears its own port's change as well
        rd(8'h00, '{8'ha7});
        wint(20, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire

// ---- test/spxia_master.sv ----
// two-wire bus master model, paced by the core clock
// assumes the bench resolves scl and sda with pull-ups
`default_nettype none
module spxia_master (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ======================================
    // bus phases, third of a bit, 1 us each
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    task automatic q(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // release scl, then wait out a stretch, bounded
    task automatic hi();
        scl_low_o = 1'b0;
        q(10);
        for (int i = 0; i < 100 && scl_i !== 1'b1; i++) q(1);
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        q(10);
        hi();
        sda_low_o = 1'b1;
        q(10);
        scl_low_o = 1'b1;
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        q(10);
        hi();
        sda_low_o = 1'b0;
        q(20);
    endtask
    // eight bits plus ack slot; sda released between frames, never left driven
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_low_o = ~d[i];
            q(10);
            hi();
            r[i] = sda_i;
            q(10);
            scl_low_o = 1'b1;
        end
        sda_low_o = 1'b0;
        q(120);
    endtask
endmodule
`default_nettype wire
